// *** logic/pnfh_host.sv ***
// Host controller that drives a parallel NOR flash through its pins.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
// Functional notes
// - Reads hold chip select and output gate low, write high, sample after access time.
// - Writes hold chip select low, output gate high, pulse write strobe low.
// - Host never issues undefined command values; the code refuses only undefined values tagged as command by bit 31.
// - Buffer start: two unlocks, load command at sector, then count minus one.
// - All buffer pairs must share the page fixed by the first address.
// - After the declared pairs, host writes the confirm command.
// - Abort shows flag bit set; host must then write abort reset sequence.
// - High-voltage read with A1 high and A0 low returns sector lock on lowest bit.
// - High-voltage read with A1 and A0 low returns the maker code.
module pnfh_host (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic [7:0]                    regAddr,
    input  wire logic [31:0]                   regWdata,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic      [31:0]                   regRdata,
    output logic      [pnfh_pkg::ADDR_W-1:0]   flashAddr,
    input  wire logic [pnfh_pkg::DATA_W-1:0]   flashDataIn,
    output logic      [pnfh_pkg::DATA_W-1:0]   flashDataOut,
    output logic                               flashDataOe_n,
    output logic                               chipSel_n,
    output logic                               outGate_n,
    output logic                               writeStrobe_n,
    output logic                               hwReset_n,
    output logic                               wordMode,
    output logic                               protectAccelPin_n,
    output logic                               accelHv,
    output logic                               autoselHv,
    input  wire logic                          readyBusyOut
);
    import pnfh_pkg::*;

    typedef enum {ST_IDLE, ST_RD_WAIT, ST_WR_LOW, ST_WR_HIGH, ST_RST_LOW, ST_RST_WAIT} pnfh_state_e;

    pnfh_state_e          state;
    logic [7:0]           cnt;
    logic [3:0]           ctrl;
    logic [ADDR_W-1:0]    addrReg;
    logic [DATA_W-1:0]    wdataReg;
    logic [DATA_W-1:0]    rdataReg;
    logic                 cmdErr;
    logic                 abortSeen;
    logic [DATA_W-1:0]    dataSync1;
    logic [DATA_W-1:0]    dataSync2;
    logic                 rbSync1;
    logic                 rbSync2;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataSync1 <= 16'h0000;
            dataSync2 <= 16'h0000;
            rbSync1   <= 1'b0;
            rbSync2   <= 1'b0;
        end else begin
            dataSync1 <= flashDataIn;
            dataSync2 <= dataSync1;
            rbSync1   <= readyBusyOut;
            rbSync2   <= rbSync1;
        end
    end

    // ------------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------------
    logic startOp;
    logic [2:0] opCode;
    assign startOp = regWrite && (regAddr == REG_CMD) && (state == ST_IDLE);
    assign opCode  = regWdata[2:0];

    // Command values outside the defined set are refused and flagged when tagged as command by bit 31.
    function automatic logic cmdDefined(input logic [15:0] v);
        logic [15:0] b;
        b = v & CMD_MASK;
        return (b == CMD_UNLOCK1) || (b == CMD_UNLOCK2) || (b == CMD_BUF_LOAD) ||
               (b == CMD_BUF_CONF) || (b == CMD_ABORT_RST);
    endfunction : cmdDefined

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= CTRL_RESET;
            addrReg  <= '0;
            wdataReg <= 16'h0000;
        end else if (regWrite) begin
            unique case (regAddr)
                REG_CTRL:  ctrl     <= regWdata[3:0];
                REG_ADDR:  addrReg  <= regWdata[ADDR_W-1:0];
                REG_WDATA: wdataReg <= regWdata[DATA_W-1:0];
                default: ;
            endcase
        end
    end

    // Status flags: hardware set wins over a software clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdErr    <= 1'b0;
            abortSeen <= 1'b0;
        end else begin
            // Host may flag a non-command value tagged as command (bit 31).
            if (startOp && opCode == OP_WRITE && regWdata[31] && !cmdDefined(wdataReg))
                cmdErr <= 1'b1;
            else if (regWrite && regAddr == REG_STATUS && regWdata[STAT_ERR_BIT])
                cmdErr <= 1'b0;
            if (state == ST_RD_WAIT && cnt == 8'h00 && dataSync2[1])
                abortSeen <= 1'b1;
            else if (regWrite && regAddr == REG_STATUS && regWdata[STAT_ABORT_BIT])
                abortSeen <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                REG_CTRL:   regRdata <= {28'h0, ctrl};
                REG_ADDR:   regRdata <= {7'h0, addrReg};
                REG_WDATA:  regRdata <= {16'h0, wdataReg};
                REG_RDATA:  regRdata <= {16'h0, rdataReg};
                REG_STATUS: regRdata <= {28'h0, cmdErr, abortSeen, rbSync2,
                                         state != ST_IDLE};
                default:    regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            cnt       <= 8'h00;
            rdataReg  <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (startOp && opCode == OP_READ) begin
                        state <= ST_RD_WAIT;
                        cnt   <= ACC_CNT + 8'd2;
                    end else if (startOp && opCode == OP_WRITE &&
                                 !(regWdata[31] && !cmdDefined(wdataReg))) begin
                        state <= ST_WR_LOW;
                        cnt   <= WP_CNT;
                    end else if (startOp && opCode == OP_HWRESET) begin
                        state <= ST_RST_LOW;
                        cnt   <= RP_CNT;
                    end
                end
                ST_RD_WAIT: begin
                    if (cnt == 8'h00) begin
                        // Byte mode keeps only the low byte.
                        rdataReg <= ctrl[CTRL_WORD_BIT] ? dataSync2
                                                        : {8'h00, dataSync2[7:0]};
                        state    <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 8'd1;
                    end
                end
                ST_WR_LOW: begin
                    if (cnt == 8'h01 || cnt == 8'h00) begin
                        state <= ST_WR_HIGH;
                        cnt   <= 8'h01;
                    end else begin
                        cnt <= cnt - 8'd1;
                    end
                end
                ST_WR_HIGH: begin
                    state <= ST_IDLE;
                end
                ST_RST_LOW: begin
                    if (cnt == 8'h00) begin
                        state <= ST_RST_WAIT;
                        cnt   <= READY_CNT;
                    end else begin
                        cnt <= cnt - 8'd1;
                    end
                end
                ST_RST_WAIT: begin
                    if (cnt == 8'h00 || rbSync2) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 8'd1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chipSel_n         <= 1'b1;
            outGate_n         <= 1'b1;
            writeStrobe_n     <= 1'b1;
            flashDataOe_n     <= 1'b1;
            flashDataOut      <= 16'h0000;
            flashAddr         <= '0;
            hwReset_n         <= 1'b0;
            wordMode          <= 1'b1;
            protectAccelPin_n <= 1'b1;
            accelHv           <= 1'b0;
            autoselHv         <= 1'b0;
        end else begin
            hwReset_n         <= !(state == ST_RST_LOW);
            wordMode          <= ctrl[CTRL_WORD_BIT];
            protectAccelPin_n <= ctrl[CTRL_PROT_BIT];
            accelHv           <= ctrl[CTRL_ACCEL_BIT];
            autoselHv         <= ctrl[CTRL_HV_BIT];
            // Address and data are frozen for the whole transfer.
            if (state == ST_IDLE) begin
                flashAddr    <= addrReg;
                flashDataOut <= wdataReg;
            end
            // Chip select stays high while idle, giving standby, and stays low through
            // the rise of the write strobe so that the data hold is met.
            chipSel_n     <= !(state == ST_RD_WAIT || state == ST_WR_LOW ||
                               state == ST_WR_HIGH);
            outGate_n     <= !(state == ST_RD_WAIT);
            writeStrobe_n <= !(state == ST_WR_LOW);
            flashDataOe_n <= !(state == ST_WR_LOW || state == ST_WR_HIGH);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_read_strobes: assert property (@(posedge clk) disable iff (!rst_n)
        !outGate_n |-> (!chipSel_n && writeStrobe_n))
        else $error("Read without chip select or with write strobe low.");
    a_write_gate_high: assert property (@(posedge clk) disable iff (!rst_n)
        !writeStrobe_n |-> (outGate_n && !chipSel_n))
        else $error("Write strobe low with output gate low.");
    a_no_contention: assert property (@(posedge clk) disable iff (!rst_n)
        !outGate_n |-> flashDataOe_n)
        else $error("Host drives data while device may drive.");
    a_reset_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(hwReset_n) |-> !hwReset_n [*5])
        else $error("Reset pulse shorter than minimum.");
    a_write_release: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(writeStrobe_n) |-> !flashDataOe_n)
        else $error("Data released before write strobe rose.");
    a_read_len: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(outGate_n) |-> !outGate_n [*3])
        else $error("Read shorter than access time.");
    a_bad_cmd: assert property (@(posedge clk) disable iff (!rst_n)
        (startOp && opCode == OP_WRITE && regWdata[31] && !cmdDefined(wdataReg))
        |=> (state == ST_IDLE && cmdErr))
        else $error("Undefined command was not refused.");
    a_mode_pin: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 wordMode == $past(ctrl[CTRL_WORD_BIT]))
        else $error("Width select does not follow control.");
    a_protect_pin: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 protectAccelPin_n == $past(ctrl[CTRL_PROT_BIT]))
        else $error("Protect pin does not follow control.");
    a_reset_wait: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_RST_WAIT) |-> ##[1:110] (state == ST_IDLE))
        else $error("Reset recovery wait overran.");
    a_write_cs_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(writeStrobe_n) |-> !chipSel_n)
        else $error("Chip select released together with the write strobe.");
    a_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!chipSel_n && $past(!chipSel_n)) |-> $stable(flashAddr))
        else $error("Address changed during a transfer.");
    a_standby_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_IDLE && $past(state == ST_IDLE)) |-> chipSel_n)
        else $error("Chip select low while idle.");
    a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !hwReset_n |-> (chipSel_n && writeStrobe_n))
        else $error("Flash accessed during the reset pulse.");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(regRead) |-> (regRdata == 32'h0000_0000))
        else $error("Read data shown outside its cycle.");
    c_read: cover property (@(posedge clk) disable iff (!rst_n) $rose(outGate_n));
    c_write: cover property (@(posedge clk) disable iff (!rst_n) $rose(writeStrobe_n));
    c_reset: cover property (@(posedge clk) disable iff (!rst_n) $rose(hwReset_n));
    c_abort: cover property (@(posedge clk) disable iff (!rst_n) $rose(abortSeen));
    c_byte_read: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(outGate_n) && !wordMode);
endmodule : pnfh_host

// *** shared/pnfh_pkg.sv ***
// Constants, commands and register map of the parallel NOR flash host controller.
package pnfh_pkg;
    // ------------------------------------------------------------------
    // Host register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_ADDR      = 8'h04;
    localparam logic [7:0]  REG_WDATA     = 8'h08;
    localparam logic [7:0]  REG_RDATA     = 8'h0C;
    localparam logic [7:0]  REG_STATUS    = 8'h10;
    localparam logic [7:0]  REG_CMD       = 8'h14;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_WORD_BIT   = 0;
    localparam int CTRL_PROT_BIT   = 1;
    localparam int CTRL_ACCEL_BIT  = 2;
    localparam int CTRL_HV_BIT     = 3;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_RDY_BIT    = 1;
    localparam int STAT_ABORT_BIT  = 2;
    localparam int STAT_ERR_BIT    = 3;
    localparam logic [3:0]  CTRL_RESET    = 4'h3;
    // ------------------------------------------------------------------
    // Host operation codes written to the command register
    // ------------------------------------------------------------------
    localparam logic [2:0]  OP_READ       = 3'h0;
    localparam logic [2:0]  OP_WRITE      = 3'h1;
    localparam logic [2:0]  OP_HWRESET    = 3'h2;
    // ------------------------------------------------------------------
    // Flash address fields
    // ------------------------------------------------------------------
    localparam int ADDR_W          = 25;
    localparam int DATA_W          = 16;
    localparam int PAGE_LSB        = 3;
    localparam int BUF_PAGE_LSB    = 5;
    localparam int SECTOR_LSB      = 16;
    localparam int BUF_WORDS       = 32;
    // Command values the device defines for buffer programming.
    localparam logic [15:0] CMD_UNLOCK1   = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2   = 16'h0055;
    localparam logic [15:0] CMD_BUF_LOAD  = 16'h0025;
    localparam logic [15:0] CMD_BUF_CONF  = 16'h0029;
    localparam logic [15:0] CMD_ABORT_RST = 16'h00F0;
    localparam logic [15:0] CMD_MASK      = 16'h00FF;
    // ------------------------------------------------------------------
    // Timing (clk is 100 ns)
    // ------------------------------------------------------------------
    localparam int CLK_NS          = 100;
    localparam int T_ACCESS_NS     = 110;
    localparam int T_WPULSE_NS     = 35;
    localparam int T_RP_NS         = 500;
    localparam int T_READY1_NS     = 10000;
    localparam int ACC_CYC   = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC    = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int READY_CYC = T_READY1_NS / CLK_NS;
    localparam logic [7:0] ACC_CNT   = 8'(ACC_CYC);
    localparam logic [7:0] WP_CNT    = 8'(WP_CYC);
    localparam logic [7:0] RP_CNT    = 8'(RP_CYC);
    localparam logic [7:0] READY_CNT = 8'(READY_CYC);
endpackage : pnfh_pkg

// *** tb/pnfh_flash_model.sv ***
// Behavioural model of the flash device behind the host controller.
`timescale 1ns/1ns
module pnfh_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5A // Arbitrary value.
) (
    input  wire logic        clk,
    input  wire logic [24:0] flashAddr,
    input  wire logic [15:0] hostData,
    input  wire logic        hostOe_n,
    input  wire logic        chipSel_n,
    input  wire logic        outGate_n,
    input  wire logic        writeStrobe_n,
    input  wire logic        hwReset_n,
    input  wire logic        protectAccelPin_n,
    input  wire logic        accelHv,
    input  wire logic        autoselHv,
    input  wire logic        wordMode,
    output logic      [15:0] dataBus,
    output logic             readyBusyOut
);
    logic [15:0] mem [256];
    logic [15:0] lastBus, lastData, bufD [32];
    logic [24:0] wrAddr, bufA [32];
    logic [19:0] page;
    logic [8:0]  sector;
    logic        toggle;
    int          st = 0;
    int          n, left;
    int          busyCnt = 0;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hFF00 | 16'(i);
        toggle = 1'b0;
        lastBus = 16'h0;
    end
    // A released bus shows a value that changes every cycle.
    always_comb begin
        if (!hostOe_n) dataBus = hostData;
        else if (!hwReset_n || chipSel_n || outGate_n) dataBus = ~lastBus;
        else if (st == 6) dataBus = {8'h00, ~lastData[7], toggle, 6'b000010};
        else if (autoselHv && busyCnt == 0) begin
            case (flashAddr[1:0])
                2'b00:   dataBus = {8'h00, MAKER_CODE};
                2'b10:   dataBus = {15'h0, flashAddr[24:16] == 9'h0};
                default: dataBus = 16'h0009;
            endcase
        end else if (wordMode) dataBus = mem[flashAddr[7:0]];
        else dataBus = {~lastBus[15:8], mem[flashAddr[7:0]][7:0]};
    end
    assign readyBusyOut = (busyCnt == 0);
    always @(posedge clk) begin
        lastBus <= dataBus;
        if (busyCnt > 0) busyCnt <= busyCnt - 1;
    end
    always @(negedge hwReset_n) begin
        st = 0;
        if (busyCnt > 0) busyCnt = 10;
    end
    always @(negedge outGate_n) toggle = ~toggle;
    always @(negedge writeStrobe_n) wrAddr = flashAddr;
    always @(posedge writeStrobe_n) begin
        if (hwReset_n && outGate_n && busyCnt == 0) begin
            lastData = hostData;
            if (accelHv && st == 0) mem[wrAddr[7:0]] &= hostData;
            else case (st)
                0: st = (hostData[7:0] == 8'hAA) ? 1 : 0;
                1: st = (hostData[7:0] == 8'h55) ? 2 : 0;
                2: begin
                    sector = wrAddr[24:16];
                    st = (hostData[7:0] == 8'h25) ? 3 : 0;
                end
                3: begin
                    n = 0;
                    left = int'(hostData) + 1;
                    st = (hostData > 16'd31) ? 6 : 4;
                end
                4: begin
                    if (n == 0) page = wrAddr[24:5];
                    st = (wrAddr[24:16] != sector || wrAddr[24:5] != page) ? 6 : 4;
                    bufA[n] = wrAddr;
                    bufD[n] = hostData;
                    n++;
                    if (st == 4 && n == left) st = 5;
                end
                5: begin
                    st = (hostData[7:0] == 8'h29) ? 0 : 6;
                    for (int i = 0; i < n; i++)
                        if (st == 0 && (protectAccelPin_n || sector != 9'h0))
                            mem[bufA[i][7:0]] &= bufD[i];
                    if (st == 0) busyCnt = 20;
                end
                default: if (hostData[7:0] == 8'hF0) st = 0;
            endcase
        end
    end
endmodule : pnfh_flash_model

// *** tb/test_pnfh_host.sv ***
// Self-checking bench for the flash host controller.
`timescale 1ns/1ns
module test_pnfh_host;
    import pnfh_pkg::*;
    logic        clk, rst_n, regWrite, regRead, flashDataOe_n, chipSel_n, outGate_n;
    logic        writeStrobe_n, hwReset_n, wordMode, protectAccelPin_n, accelHv;
    logic        autoselHv, readyBusyOut;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, val;
    logic [24:0] flashAddr;
    logic [15:0] flashDataIn, flashDataOut;
    int          failures, checked;
    pnfh_host dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .flashAddr(flashAddr),
        .flashDataIn(flashDataIn), .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n),
        .chipSel_n(chipSel_n), .outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n),
        .hwReset_n(hwReset_n), .wordMode(wordMode), .protectAccelPin_n(protectAccelPin_n),
        .accelHv(accelHv), .autoselHv(autoselHv), .readyBusyOut(readyBusyOut));
    pnfh_flash_model #(.MAKER_CODE(8'h5A)) flash (.clk(clk), .flashAddr(flashAddr),
        .hostData(flashDataOut), .hostOe_n(flashDataOe_n), .chipSel_n(chipSel_n),
        .outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n), .hwReset_n(hwReset_n),
        .protectAccelPin_n(protectAccelPin_n), .accelHv(accelHv), .autoselHv(autoselHv),
        .wordMode(wordMode), .dataBus(flashDataIn), .readyBusyOut(readyBusyOut));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask : rd
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic poll(input int pos, input logic want);
        for (int i = 0; i < 300; i++) begin
            rd(REG_STATUS, val);
            if (val[pos] === want) return;
        end
        chk("status wait", 32'(want), 32'(val[pos]));
    endtask : poll
    // Runs one flash transfer and waits until the controller is idle again.
    task automatic op(input logic [2:0] o, input logic [24:0] a, input logic [15:0] d,
                      input logic c);
        wr(REG_ADDR, 32'(a));
        wr(REG_WDATA, 32'(d));
        wr(REG_CMD, {c, 28'h0, o});
        poll(STAT_BUSY_BIT, 1'b0);
        poll(STAT_RDY_BIT, 1'b1);
    endtask : op
    task automatic fread(input logic [24:0] a, input logic [31:0] exp, input logic [31:0] m,
                         input string what);
        op(OP_READ, a, 16'h0, 1'b0);
        rd(REG_RDATA, val);
        chk(what, exp, val & m);
    endtask : fread
    task automatic start(input logic [15:0] cnt);
        op(OP_WRITE, 25'h0, CMD_UNLOCK1, 1'b1);
        op(OP_WRITE, 25'h0, CMD_UNLOCK2, 1'b1);
        op(OP_WRITE, 25'h0, CMD_BUF_LOAD, 1'b1);
        op(OP_WRITE, 25'h0, cnt, 1'b0);
    endtask : start
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        rst_n    = 1'b0;
        regAddr  = 8'h00;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead  = 1'b0;
        failures = 0;
        checked  = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_CTRL, val);
        chk("ctrl", 32'(CTRL_RESET), val);
        rd(8'h18, val);
        chk("unmapped", 32'h0, val);
        fread(25'h5, 32'hFF05, 32'hFFFF, "array");
        start(16'h1);
        op(OP_WRITE, 25'h10, 16'h1234, 1'b0);
        op(OP_WRITE, 25'h11, 16'h00F0, 1'b0);
        op(OP_WRITE, 25'h0, CMD_BUF_CONF, 1'b1);
        fread(25'h10, 32'h1210, 32'hFFFF, "prog0");
        fread(25'h11, 32'h0010, 32'hFFFF, "prog1");
        start(16'h0);
        op(OP_WRITE, 25'h10, 16'hFFFF, 1'b0);
        op(OP_WRITE, 25'h0, CMD_BUF_CONF, 1'b1);
        fread(25'h10, 32'h1210, 32'hFFFF, "reprog");
        $display("test program done");
        for (int k = 0; k < 4; k++) begin
            start((k == 0) ? 16'h20 : 16'h1);
            if (k > 0) op(OP_WRITE, 25'h10, 16'h0, 1'b0);
            if (k == 1) op(OP_WRITE, 25'h10011, 16'h0, 1'b0);
            if (k == 2) op(OP_WRITE, 25'h30, 16'h0, 1'b0);
            if (k == 3) op(OP_WRITE, 25'h11, 16'h0, 1'b0);
            if (k == 3) op(OP_WRITE, 25'h0, CMD_UNLOCK2, 1'b1);
            fread(25'h10, 32'h82, 32'h82, "abort status");
            rd(REG_STATUS, val);
            chk("abort seen", 32'h4, val & 32'h4);
            op(OP_WRITE, 25'h0, CMD_ABORT_RST, 1'b1);
            wr(REG_STATUS, 32'hC);
            fread(25'h10, 32'h1210, 32'hFFFF, "after abort");
        end
        $display("test abort done");
        op(OP_WRITE, 25'h0, 16'h0077, 1'b1);
        rd(REG_STATUS, val);
        chk("undefined cmd", 32'h8, val & 32'h8);
        wr(REG_CTRL, 32'h1);
        start(16'h0);
        op(OP_WRITE, 25'h14, 16'h0, 1'b0);
        op(OP_WRITE, 25'h0, CMD_BUF_CONF, 1'b1);
        wr(REG_CTRL, 32'h3);
        fread(25'h14, 32'hFF14, 32'hFFFF, "protect");
        wr(REG_CTRL, 32'hB);
        fread(25'h0, 32'h5A, 32'hFF, "maker");
        fread(25'h2, 32'h1, 32'h1, "lock0");
        fread(25'h10002, 32'h0, 32'h1, "lock1");
        fread(25'h3, 32'h09, 32'hFF, "security");
        wr(REG_CTRL, 32'h7);
        op(OP_WRITE, 25'h20, 16'h0F0F, 1'b0);
        wr(REG_CTRL, 32'h3);
        fread(25'h20, 32'h0F00, 32'hFFFF, "accel");
        wr(REG_CTRL, 32'h2);
        fread(25'h5, 32'h0005, 32'hFFFF, "byte read");
        chk("width pin", 32'h0, 32'(wordMode));
        wr(REG_CTRL, 32'h3);
        $display("test pins done");
        start(16'h20);
        op(OP_HWRESET, 25'h0, 16'h0, 1'b0);
        chk("reset pin", 32'h1, 32'(hwReset_n));
        fread(25'h5, 32'hFF05, 32'hFFFF, "after reset");
        $display("test reset done");
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : test_pnfh_host
